// *** rtl/eeprom_defines.svh ***
// Summary of operation
// - read starts like write, read bit one
// - pointer holds last accessed address plus one
// - ack read control byte, send byte MSB-first
// - master nack plus stop ends read
// - write control plus word address loads pointer
// - repeated start after address keeps pointer
// - read control after restart returns loaded byte
// - master ack requests next sequential byte
// - pointer advances after every byte read
// - low supply blocks erase and write
// - control code must match to acknowledge
// - top block bit ignored, two select block
// - after nack data line left released
// - no ack while programming cycle busy
`ifndef EEPROM_DEFINES_SVH
`define EEPROM_DEFINES_SVH
`define DEV_CODE 4'h0a
`define ADDR_W 10
`define MEM_DEPTH 1024
`define ADDR_MAX 10'h03ff
`define BIT_LAST 4'h7
`define BIT_ACK 4'h8
`endif

// *** rtl/eeprom_pkg.sv ***
package eeprom_pkg;
	typedef enum logic [6:0] {
		ST_IDLE = 7'b000_0001,
		ST_CTRL = 7'b000_0010,
		ST_CACK = 7'b000_0100,
		ST_ADDR = 7'b000_1000,
		ST_AACK = 7'b001_0000,
		ST_SEND = 7'b010_0000,
		ST_MACK = 7'b100_0000
	} phase_t;
	typedef struct packed {
		logic scl;
		logic sda;
	} line_t;
	typedef struct packed {
		logic rise;
		logic fall;
		logic start;
		logic stop;
	} bus_ev_t;
endpackage

// *** rtl/line_sync.sv ***
`timescale 1ns/10ps
`include "eeprom_defines.svh"
// three flops per line, then edge and condition detection on the clean copy and the flop before it
module line_sync
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire eeprom_pkg::line_t raw,
	output eeprom_pkg::line_t clean,
	output eeprom_pkg::bus_ev_t ev
);
	eeprom_pkg::line_t meta_r;
	eeprom_pkg::line_t sync_r;
	eeprom_pkg::line_t prev_r;
	eeprom_pkg::bus_ev_t ev_nxt;
	always_comb
	begin
		ev_nxt.rise = sync_r.scl & ~prev_r.scl;
		ev_nxt.fall = ~sync_r.scl & prev_r.scl;
		ev_nxt.start = sync_r.scl & prev_r.scl & prev_r.sda & ~sync_r.sda;
		ev_nxt.stop = sync_r.scl & prev_r.scl & ~prev_r.sda & sync_r.sda;
	end
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta_r <= 2'b11;
			sync_r <= 2'b11;
			prev_r <= 2'b11;
		end
		else
		begin
			meta_r <= raw;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end
	assign clean = prev_r;
	assign ev = ev_nxt;
endmodule

// *** rtl/eeprom_read_path.sv ***
`timescale 1ns/10ps
`include "eeprom_defines.svh"
// serial eeprom slave: control byte decode, pointer load, byte reads
module eeprom_read_path
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic prog_busy,
	input wire logic supply_low,
	output logic write_inhibit,
	output logic [9:0] pointer,
	input wire logic [7:0] init_wdata,
	input wire logic init_we,
	input wire logic [9:0] init_waddr
);
	eeprom_pkg::line_t raw;
	eeprom_pkg::line_t clean;
	eeprom_pkg::bus_ev_t ev;
	eeprom_pkg::phase_t st_r, st_nxt;
	logic [7:0] mem [0:`MEM_DEPTH-1];
	logic [7:0] sh_r, sh_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [9:0] ptr_r, ptr_nxt;
	logic oe_r, oe_nxt;
	logic supply_meta_r;
	logic inh_r;
	logic is_read_r, is_read_nxt;
	logic [7:0] rdata;

	assign raw.scl = scl_in;
	assign raw.sda = sda_in;

	line_sync u_sync
	(
		.mclk(mclk),
		.arst_n(arst_n),
		.raw(raw),
		.clean(clean),
		.ev(ev)
	);

	// load port stands in for the erase/write path; gated by the synchronised supply flag
	always_ff @(posedge mclk)
	begin
		if (init_we && !inh_r)
			mem[init_waddr] <= init_wdata;
	end
	assign rdata = mem[ptr_r];

	always_comb
	begin
		st_nxt = st_r;
		sh_nxt = sh_r;
		cnt_nxt = cnt_r;
		ptr_nxt = ptr_r;
		oe_nxt = oe_r;
		is_read_nxt = is_read_r;
		if (ev.stop)
		begin
			st_nxt = eeprom_pkg::ST_IDLE;
			oe_nxt = 1'b0;
		end
		else if (ev.start)
		begin
			// restart mid-write leaves the loaded pointer untouched
			st_nxt = eeprom_pkg::ST_CTRL;
			cnt_nxt = 4'h0;
			oe_nxt = 1'b0;
		end
		else
		begin
			unique case (st_r)
				eeprom_pkg::ST_IDLE:
				begin
					oe_nxt = 1'b0;
				end
				eeprom_pkg::ST_CTRL, eeprom_pkg::ST_ADDR:
				begin
					if (ev.rise)
					begin
						sh_nxt = {sh_r[6:0], clean.sda};
						cnt_nxt = cnt_r + 4'h1;
					end
					if (ev.fall && cnt_r == `BIT_ACK)
					begin
						cnt_nxt = 4'h0;
						if (st_r == eeprom_pkg::ST_CTRL)
						begin
							// code match and idle array required for an ack
							if (sh_r[7:4] == `DEV_CODE && !prog_busy)
							begin
								st_nxt = eeprom_pkg::ST_CACK;
								oe_nxt = 1'b1;
								is_read_nxt = sh_r[0];
								ptr_nxt = {sh_r[2:1], ptr_r[7:0]};
							end
							else
								st_nxt = eeprom_pkg::ST_IDLE;
						end
						else
						begin
							ptr_nxt = {ptr_r[9:8], sh_r};
							st_nxt = eeprom_pkg::ST_AACK;
							oe_nxt = 1'b1;
						end
					end
				end
				eeprom_pkg::ST_CACK:
				begin
					if (ev.fall)
					begin
						cnt_nxt = 4'h0;
						if (is_read_r)
						begin
							st_nxt = eeprom_pkg::ST_SEND;
							sh_nxt = rdata;
							oe_nxt = ~rdata[7];
						end
						else
						begin
							st_nxt = eeprom_pkg::ST_ADDR;
							oe_nxt = 1'b0;
						end
					end
				end
				eeprom_pkg::ST_AACK:
				begin
					if (ev.fall)
					begin
						// data bytes of a write are not handled here; wait for restart or stop
						st_nxt = eeprom_pkg::ST_IDLE;
						oe_nxt = 1'b0;
					end
				end
				eeprom_pkg::ST_SEND:
				begin
					if (ev.fall)
					begin
						if (cnt_r == `BIT_LAST)
						begin
							st_nxt = eeprom_pkg::ST_MACK;
							oe_nxt = 1'b0;
							ptr_nxt = (ptr_r == `ADDR_MAX) ? 10'h000 : ptr_r + 10'h001;
						end
						else
						begin
							cnt_nxt = cnt_r + 4'h1;
							sh_nxt = {sh_r[6:0], 1'b0};
							oe_nxt = ~sh_r[6];
						end
					end
				end
				eeprom_pkg::ST_MACK:
				begin
					if (ev.rise)
						is_read_nxt = ~clean.sda;
					if (ev.fall)
					begin
						cnt_nxt = 4'h0;
						if (is_read_r)
						begin
							st_nxt = eeprom_pkg::ST_SEND;
							sh_nxt = rdata;
							oe_nxt = ~rdata[7];
						end
						else
						begin
							st_nxt = eeprom_pkg::ST_IDLE;
							oe_nxt = 1'b0;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_r <= eeprom_pkg::ST_IDLE;
			sh_r <= 8'h00;
			cnt_r <= 4'h0;
			ptr_r <= 10'h000;
			oe_r <= 1'b0;
			is_read_r <= 1'b0;
			supply_meta_r <= 1'b1;
			inh_r <= 1'b1;
		end
		else
		begin
			st_r <= st_nxt;
			sh_r <= sh_nxt;
			cnt_r <= cnt_nxt;
			ptr_r <= ptr_nxt;
			oe_r <= oe_nxt;
			is_read_r <= is_read_nxt;
			// detector output is asynchronous: two flops, so inhibit lags by two cycles
			supply_meta_r <= supply_low;
			inh_r <= supply_meta_r;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe = oe_r;
	assign write_inhibit = inh_r;
	assign pointer = ptr_r;

	ack_on_match_a: assert property (@(posedge mclk) disable iff (!arst_n)
		(st_r == eeprom_pkg::ST_CTRL && ev.fall && cnt_r == `BIT_ACK && !ev.start && !ev.stop
		&& sh_r[7:4] == `DEV_CODE && !prog_busy) |=> sda_oe)
		else $error("no ack on matching control byte");

	busy_no_ack_a: assert property (@(posedge mclk) disable iff (!arst_n)
		(st_r == eeprom_pkg::ST_CTRL && ev.fall && cnt_r == `BIT_ACK && prog_busy)
		|=> st_r != eeprom_pkg::ST_CACK)
		else $error("ack while programming");

	ptr_step_a: assert property (@(posedge mclk) disable iff (!arst_n)
		(st_r == eeprom_pkg::ST_SEND && st_nxt == eeprom_pkg::ST_MACK)
		|=> ptr_r == (($past(ptr_r) == `ADDR_MAX) ? 10'h000 : $past(ptr_r) + 10'h001))
		else $error("pointer did not advance");

	stop_release_a: assert property (@(posedge mclk) disable iff (!arst_n)
		ev.stop |=> !sda_oe && st_r == eeprom_pkg::ST_IDLE)
		else $error("bus held after stop");

	nack_release_a: assert property (@(posedge mclk) disable iff (!arst_n)
		st_r == eeprom_pkg::ST_MACK |-> !sda_oe)
		else $error("data line driven in master ack slot");

	restart_keep_a: assert property (@(posedge mclk) disable iff (!arst_n)
		ev.start |=> $stable(ptr_r))
		else $error("pointer lost on restart");

	inhibit_follow_a: assert property (@(posedge mclk) disable iff (!arst_n)
		supply_low [*3] |-> write_inhibit)
		else $error("write not inhibited at low supply");

	msb_first_a: assert property (@(posedge mclk) disable iff (!arst_n)
		(st_r == eeprom_pkg::ST_CACK && is_read_r && ev.fall && !ev.start && !ev.stop)
		|=> sda_oe == !rdata[7] && st_r == eeprom_pkg::ST_SEND)
		else $error("read byte not started");

	code_refuse_a: assert property (@(posedge mclk) disable iff (!arst_n)
		(st_r == eeprom_pkg::ST_CTRL && ev.fall && cnt_r == `BIT_ACK && !ev.start && !ev.stop
		&& sh_r[7:4] != `DEV_CODE) |=> st_r == eeprom_pkg::ST_IDLE && !sda_oe)
		else $error("ack on foreign control code");

	busy_idle_a: assert property (@(posedge mclk) disable iff (!arst_n)
		(st_r == eeprom_pkg::ST_CTRL && ev.fall && cnt_r == `BIT_ACK && !ev.start && !ev.stop
		&& prog_busy) |=> st_r == eeprom_pkg::ST_IDLE && !sda_oe)
		else $error("busy refusal did not go idle");

	ack_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
		(st_r == eeprom_pkg::ST_CACK || st_r == eeprom_pkg::ST_AACK) |-> sda_oe)
		else $error("ack not held in ack slot");

	idle_release_a: assert property (@(posedge mclk) disable iff (!arst_n)
		st_r == eeprom_pkg::ST_IDLE |-> !sda_oe)
		else $error("data line driven while idle");

	send_msb_a: assert property (@(posedge mclk) disable iff (!arst_n)
		st_r == eeprom_pkg::ST_SEND |-> sda_oe == !sh_r[7])
		else $error("data line not showing top shift bit");

	ptr_wrap_a: assert property (@(posedge mclk) disable iff (!arst_n)
		(st_r == eeprom_pkg::ST_SEND && st_nxt == eeprom_pkg::ST_MACK && ptr_r == `ADDR_MAX)
		|=> ptr_r == 10'h000)
		else $error("pointer did not wrap to zero");

	seq_next_a: assert property (@(posedge mclk) disable iff (!arst_n)
		(st_r == eeprom_pkg::ST_MACK && ev.fall && is_read_r && !ev.start && !ev.stop)
		|=> st_r == eeprom_pkg::ST_SEND)
		else $error("master ack did not start next byte");

	nack_idle_a: assert property (@(posedge mclk) disable iff (!arst_n)
		(st_r == eeprom_pkg::ST_MACK && ev.fall && !is_read_r && !ev.start && !ev.stop)
		|=> st_r == eeprom_pkg::ST_IDLE && !sda_oe)
		else $error("transmit continued after master nack");

	addr_load_a: assert property (@(posedge mclk) disable iff (!arst_n)
		(st_r == eeprom_pkg::ST_ADDR && ev.fall && cnt_r == `BIT_ACK && !ev.start && !ev.stop)
		|=> ptr_r[7:0] == $past(sh_r) && sda_oe && st_r == eeprom_pkg::ST_AACK)
		else $error("word address not loaded");

	start_ctrl_a: assert property (@(posedge mclk) disable iff (!arst_n)
		ev.start |=> st_r == eeprom_pkg::ST_CTRL && cnt_r == 4'h0 && !sda_oe)
		else $error("start did not open a control byte");

	bit_count_a: assert property (@(posedge mclk) disable iff (!arst_n)
		cnt_r <= `BIT_ACK)
		else $error("bit counter out of range");

	inhibit_clear_a: assert property (@(posedge mclk) disable iff (!arst_n)
		!supply_low [*3] |-> !write_inhibit)
		else $error("write inhibited at good supply");

	block_sel_a: assert property (@(posedge mclk) disable iff (!arst_n)
		(st_r == eeprom_pkg::ST_CTRL && ev.fall && cnt_r == `BIT_ACK && !ev.start && !ev.stop
		&& sh_r[7:4] == `DEV_CODE && !prog_busy) |-> ptr_nxt[9:8] == sh_r[2:1])
		else $error("block select not taken into pointer");

	aack_exit_a: assert property (@(posedge mclk) disable iff (!arst_n)
		(st_r == eeprom_pkg::ST_AACK && ev.fall && !ev.start && !ev.stop)
		|=> st_r == eeprom_pkg::ST_IDLE && !sda_oe && $stable(ptr_r))
		else $error("address ack exit lost pointer or bus");
endmodule

// *** dv/bus_master_model.sv ***
`timescale 1ns/10ps
// two-wire master; every line change lands on a falling mclk edge
module bus_master_model
(
	input wire logic mclk,
	input wire logic sda,
	output logic scl,
	output logic sda_low
);
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// release first, then raise scl late enough that a held ack has let go
	task automatic start();
		wait_clk(2);
		sda_low = 1'b0;
		wait_clk(4);
		scl = 1'b1;
		wait_clk(4);
		sda_low = 1'b1;
		wait_clk(4);
		scl = 1'b0;
	endtask
	task automatic stop();
		wait_clk(2);
		sda_low = 1'b1;
		wait_clk(2);
		scl = 1'b1;
		wait_clk(4);
		sda_low = 1'b0;
		wait_clk(4);
	endtask
	// sample near the end of the high phase, where the device data has settled
	task automatic bit_io(input logic b, output logic r);
		wait_clk(2);
		sda_low = !b;
		wait_clk(2);
		scl = 1'b1;
		wait_clk(3);
		r = sda;
		wait_clk(1);
		scl = 1'b0;
	endtask
	// a low ack_out acknowledges; a high one leaves the line to the pull-up
	task automatic xfer(input logic [7:0] d, input logic ack_out, output logic [7:0] q, output logic ack_in);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(ack_out, ack_in);
	endtask
endmodule

// *** dv/eeprom_serial_read_path_tb_top.sv ***
`timescale 1ns/10ps
module eeprom_serial_read_path_tb_top;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic prog_busy = 1'b0;
	logic supply_low = 1'b0;
	logic scl, sda_low, sda_out, sda_oe, write_inhibit;
	logic [9:0] pointer;
	logic [7:0] img [1024];
	logic init_we = 1'b0;
	logic [7:0] init_wdata = 8'h00;
	logic [9:0] init_waddr = 10'h000;
	int failures = 0;
	int checks_done = 0;
	// pull-up: high unless either party pulls low
	wire logic sda = !(sda_low || (sda_oe && !sda_out));
	always #20 mclk = ~mclk;
	bus_master_model i_bus_master_model (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));
	eeprom_read_path i_eeprom_read_path (.mclk(mclk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .prog_busy(prog_busy), .supply_low(supply_low),
		.write_inhibit(write_inhibit), .pointer(pointer), .init_wdata(init_wdata), .init_we(init_we),
		.init_waddr(init_waddr));
	task automatic tally_and_finish();
		$display("checks_done=%0d failures=%0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic cmp(input logic [9:0] got, input logic [9:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		cmp({9'h000, got}, {9'h000, exp});
	endtask
	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		cmp({2'b00, got}, {2'b00, exp});
	endtask
	// random read loads the pointer first; otherwise a current-address read
	task automatic seq_read(input logic [9:0] a, input int n, input logic rnd, input logic b2);
		logic [7:0] q;
		logic k;
		i_bus_master_model.start();
		if (rnd)
		begin
			i_bus_master_model.xfer({4'ha, b2, a[9:8], 1'b0}, 1'b1, q, k);
			cmp_bit(k, 1'b0);
			i_bus_master_model.xfer(a[7:0], 1'b1, q, k);
			cmp_bit(k, 1'b0);
			i_bus_master_model.start();
		end
		i_bus_master_model.xfer({4'ha, b2, a[9:8], 1'b1}, 1'b1, q, k);
		cmp_bit(k, 1'b0);
		for (int i = 0; i < n; i++)
		begin
			i_bus_master_model.xfer(8'hff, i == n - 1, q, k);
			cmp_byte(q, img[10'(a + i)]);
		end
		i_bus_master_model.wait_clk(6);
		cmp_bit(sda, 1'b1);
		i_bus_master_model.stop();
		cmp(pointer, 10'(a + n));
	endtask
	task automatic refuse(input logic [7:0] c);
		logic [7:0] q;
		logic k;
		i_bus_master_model.start();
		i_bus_master_model.xfer(c, 1'b1, q, k);
		cmp_bit(k, 1'b1);
		i_bus_master_model.stop();
	endtask
	initial
	begin
		logic [9:0] a;
		int n;
		void'($urandom(56193));
		repeat (12) @(negedge mclk);
		arst_n = 1'b1;
		repeat (4) @(negedge mclk);
		cmp_bit(write_inhibit, 1'b0);
		// preload through the load port, one location per cycle
		foreach (img[i])
		begin
			img[i] = 8'($urandom);
			init_waddr = 10'(i);
			init_wdata = img[i];
			init_we = 1'b1;
			@(negedge mclk);
		end
		init_we = 1'b0;
		supply_low = 1'b1;
		repeat (2) @(negedge mclk);
		cmp_bit(write_inhibit, 1'b1);
		// a write at low supply must leave the array alone; the first read below covers it
		init_waddr = 10'h3ff;
		init_wdata = ~img[10'h3ff];
		init_we = 1'b1;
		@(negedge mclk);
		init_we = 1'b0;
		supply_low = 1'b0;
		seq_read(10'h3fe, 4, 1'b1, 1'b0);
		seq_read(10'h002, 3, 1'b0, 1'b1);
		refuse(8'hb1);
		prog_busy = 1'b1;
		refuse(8'ha1);
		prog_busy = 1'b0;
		repeat (6)
		begin
			a = 10'($urandom);
			n = 1 + $urandom % 4;
			seq_read(a, n, 1'b1, 1'($urandom));
			seq_read(10'(a + n), 1, 1'b0, 1'b0);
		end
		tally_and_finish();
	end
	// the whole sequence needs well under a quarter of this span
	initial
	begin
		#2000000;
		failures++;
		tally_and_finish();
	end
endmodule
